// ==== pin_edge_sync.sv ====
`timescale 1ns/1ps
module pin_edge_sync
    import timer_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       pin_i,
    input  wire logic [2:0] clock_select_i,
    output logic            pulse_o
);
    // ==========================================================
    // synchroniser and edge detector
    // the half-cycle latch is folded into the first flop: same worst case
    logic sync1_r, sync1_nxt;
    logic sync2_r, sync2_nxt;
    logic prev_r,  prev_nxt;

    always_comb begin
        sync1_nxt = pin_i;
        sync2_nxt = sync1_r;
        prev_nxt  = sync2_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            prev_r  <= prev_nxt;
        end
    end

    // counter moves on the edge after this pulse, about three cycles in all
    always_comb begin
        pulse_o = 1'b0;
        if (clock_select_i == CS_EXT_RISE)
            pulse_o = sync2_r && !prev_r;
        else if (clock_select_i == CS_EXT_FALL)
            pulse_o = !sync2_r && prev_r;
    end
endmodule

// ==== shared_prescaler.sv ====
`timescale 1ns/1ps
module shared_prescaler
    import timer_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       prescaler_reset_i,
    output logic [3:0]      taps_o
);
    // ==========================================================
    // free running divider, taps pulse once per period
    logic [PRESCALE_BITS-1:0] cnt_r, cnt_nxt;

    always_comb begin
        if (prescaler_reset_i)
            cnt_nxt = '0;
        else
            cnt_nxt = cnt_r + 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

    // the held reset also masks taps so every timer on a prescaler tap halts together; external pin sources keep counting
    always_comb begin
        taps_o[0] = !prescaler_reset_i && (&cnt_r[2:0]);
        taps_o[1] = !prescaler_reset_i && (&cnt_r[5:0]);
        taps_o[2] = !prescaler_reset_i && (&cnt_r[7:0]);
        taps_o[3] = !prescaler_reset_i && (&cnt_r[9:0]);
    end
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import timer_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc, stb, we, ack, cap_pin = 1'b0;
    logic        ext1 = 1'b0, ext0 = 1'b0, cmpa = 1'b0, cmpb = 1'b0, top = 1'b0;
    logic        ovf = 1'b0, gie = 1'b1, tick1, tick0, comp = 1'b0;
    logic [11:0] adr;
    logic [3:0]  sel, irq, wm, vack = 4'h0;
    logic [31:0] wdat, rdat;
    logic [15:0] cnt = 16'h0000, cap, seed = 16'hB55B, s2;
    logic [2:0]  cs1, cs0;
    logic [7:0]  q;
    int          errors = 0, comparisons = 0, n1 = 0, n0 = 0, m1, m0;

    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        n1 <= n1 + int'(tick1 === 1'b1);
        n0 <= n0 + int'(tick0 === 1'b1);
    end

    wb_cpu cpu (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
                .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    timer_capture_irq uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .capture_pin_i(cap_pin), .comparator_i(comp),
        .ext_count_pin1_i(ext1), .ext_count_pin0_i(ext0), .count_value_i(cnt),
        .cmp_a_match_i(cmpa), .cmp_b_match_i(cmpb), .top_i(top), .overflow_i(ovf),
        .global_irq_enable_i(gie), .vector_ack_i(vack), .timer1_tick_o(tick1),
        .timer0_tick_o(tick0), .timer1_clock_select_o(cs1), .timer0_clock_select_o(cs0),
        .waveform_mode_o(wm), .capture_value_o(cap), .irq_req_o(irq));

    // ==========================================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int ticks(input int c, input int s);
        case (s)
            0: return 0;
            1: return c;
            2: return c / 8;
            3: return c / 64;
            4: return c / 256;
            default: return c / 1024;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        cpu.xfer(1'b1, idx, d, q);
    endtask
    task automatic reg_chk(input string nm, input logic [9:0] idx, input logic [7:0] e);
        cpu.xfer(1'b0, idx, 8'h00, q);
        chk(nm, {8'h00, e}, {8'h00, q});
    endtask
    task automatic span(input int c, input logic [2:0] a, input logic [2:0] b,
                        input int e1, input int e0);
        wr(IDX_CTRL_B, {5'h00, a});
        wr(IDX_T0_SEL, {5'h00, b});
        m1 = n1;
        m0 = n0;
        repeat (c) @(posedge clk_i);
        chk("t1 ticks", 16'(e1), 16'(n1 - m1));
        chk("t0 ticks", 16'(e0), 16'(n0 - m0));
        chk("t1 select", 16'(a), 16'(cs1));
        chk("t0 select", 16'(b), 16'(cs0));
    endtask
    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_i);
        errors++;
        final_report();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        reg_chk("mask rst", IDX_IRQ_MASK, 8'h00);
        reg_chk("unmapped", 10'h3FF, 8'h00);
        wr(IDX_IRQ_MASK, 8'hFF);
        reg_chk("mask", IDX_IRQ_MASK, 8'h27);
        wr(IDX_CTRL_B, 8'h00);
        @(posedge clk_i) cmpa <= 1'b1;
        @(posedge clk_i) cmpa <= 1'b0;
        reg_chk("no tick cmp", IDX_IRQ_FLAGS, 8'h00);
        wr(IDX_CTRL_B, 8'h01);
        @(posedge clk_i) {ovf, cmpa, cmpb, top} <= 4'hF;
        @(posedge clk_i) {ovf, cmpa, cmpb, top} <= 4'h0;
        reg_chk("flags", IDX_IRQ_FLAGS, 8'h07);
        chk("irq", 16'h0007, {12'h000, irq});
        wr(IDX_IRQ_FLAGS, 8'hD8);
        reg_chk("zero write", IDX_IRQ_FLAGS, 8'h07);
        wr(IDX_IRQ_FLAGS, 8'h02);
        reg_chk("w1c", IDX_IRQ_FLAGS, 8'h05);
        @(posedge clk_i) vack <= 4'h5;
        @(posedge clk_i) vack <= 4'h0;
        reg_chk("vector", IDX_IRQ_FLAGS, 8'h00);
        @(posedge clk_i) {ovf, vack} <= 5'h11;
        @(posedge clk_i) {ovf, vack} <= 5'h00;
        reg_chk("set wins", IDX_IRQ_FLAGS, 8'h01);
        wr(IDX_IRQ_FLAGS, 8'h01);
        wr(IDX_CTRL_A, 8'h0C);
        chk("wm", 16'h000C, {12'h000, wm});
        @(posedge clk_i) {top, cap_pin} <= 2'b11;
        @(posedge clk_i) {top, cap_pin} <= 2'b00;
        reg_chk("top cap", IDX_IRQ_FLAGS, 8'h20);
        chk("irq cap", 16'h0008, {12'h000, irq});
        @(posedge clk_i) gie <= 1'b0;
        @(posedge clk_i) chk("irq off", 16'h0000, {12'h000, irq});
        gie <= 1'b1;
        @(posedge clk_i) vack <= 4'h8;
        @(posedge clk_i) vack <= 4'h0;
        reg_chk("cap vector", IDX_IRQ_FLAGS, 8'h00);
        wr(IDX_CTRL_A, 8'h00);
        wr(IDX_CTRL_B, 8'h41);
        // a capture between the two byte reads must not tear the value
        repeat (3) begin
            seed = lfsr(seed);
            s2 = lfsr(seed);
            @(posedge clk_i) {cnt, cap_pin} <= {seed, 1'b1};
            repeat (4) @(posedge clk_i);
            {cnt, cap_pin} <= {~seed, 1'b0};
            repeat (4) @(posedge clk_i);
            chk("capture", seed, cap);
            reg_chk("cap lo", IDX_CAP_LO, seed[7:0]);
            {cnt, cap_pin} <= {s2, 1'b1};
            repeat (4) @(posedge clk_i);
            reg_chk("cap hi", IDX_CAP_HI, seed[15:8]);
            cap_pin <= 1'b0;
            reg_chk("cap flag", IDX_IRQ_FLAGS, 8'h20);
            wr(IDX_IRQ_FLAGS, 8'h20);
        end
        // comparator source, falling edge: the rising edge must not capture
        wr(IDX_CTRL_B, 8'h21);
        @(posedge clk_i) {cnt, comp} <= {s2, 1'b1};
        @(posedge clk_i) {cnt, comp} <= {seed, 1'b0};
        repeat (2) @(posedge clk_i);
        chk("cmp capture", seed, cap);
        for (int i = 0; i <= 5; i++) begin
            span(2048, 3'(i), 3'(5 - i), ticks(2048, i), ticks(2048, 5 - i));
        end
        wr(IDX_PRESCALE, 8'h01);
        reg_chk("pre clr", IDX_PRESCALE, 8'h00);
        wr(IDX_PRESCALE, 8'h81);
        span(64, CS_DIRECT, CS_DIV8, 0, 0);
        reg_chk("pre hold", IDX_PRESCALE, 8'h81);
        wr(IDX_PRESCALE, 8'h00);
        span(64, CS_DIRECT, CS_DIV8, 64, 8);
        wr(IDX_CTRL_B, {5'h00, CS_EXT_RISE});
        wr(IDX_T0_SEL, {5'h00, CS_EXT_FALL});
        repeat (4) @(posedge clk_i);
        m1 = n1;
        m0 = n0;
        // half periods of two cycles; pins stable around select changes
        repeat (8) begin
            {ext1, ext0} <= 2'b11;
            repeat (2) @(posedge clk_i);
            {ext1, ext0} <= 2'b00;
            repeat (2) @(posedge clk_i);
        end
        repeat (6) @(posedge clk_i);
        chk("rise count", 16'd8, 16'(n1 - m1));
        chk("fall count", 16'd8, 16'(n0 - m0));
        wr(IDX_CTRL_B, 8'h00);
        final_report();
    end
endmodule

// ==== timer_capture_irq.sv ====
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module timer_capture_irq
    import timer_pkg::*;
#(
    parameter int ADR_W = 12
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        capture_pin_i,
    input  wire logic        comparator_i,
    input  wire logic        ext_count_pin1_i,
    input  wire logic        ext_count_pin0_i,
    input  wire logic [15:0] count_value_i,
    input  wire logic        cmp_a_match_i,
    input  wire logic        cmp_b_match_i,
    input  wire logic        top_i,
    input  wire logic        overflow_i,
    input  wire logic        global_irq_enable_i,
    input  wire logic [3:0]  vector_ack_i,
    output logic             timer1_tick_o,
    output logic             timer0_tick_o,
    output logic [2:0]       timer1_clock_select_o,
    output logic [2:0]       timer0_clock_select_o,
    output logic [3:0]       waveform_mode_o,
    output logic [15:0]      capture_value_o,
    output logic [3:0]       irq_req_o
);
    // ==========================================================
    // elaboration check
    if (ADR_W < 12) begin : g_adr_check
        $error("address width too small for the register map");
    end

    // ==========================================================
    // register state
    logic [7:0]  irq_mask_r,  irq_mask_nxt;
    logic [7:0]  flags_r,     flags_nxt;
    logic [15:0] capture_r,   capture_nxt;
    logic [7:0]  temp_r,      temp_nxt;
    logic [7:0]  ctrl_a_r,    ctrl_a_nxt;
    logic [7:0]  ctrl_b_r,    ctrl_b_nxt;
    logic [2:0]  t0_sel_r,    t0_sel_nxt;
    logic        pre_rst_r,   pre_rst_nxt;
    logic        sync_hold_r, sync_hold_nxt;
    logic        cap_prev_r,  cap_prev_nxt;
    logic        ack_r,       ack_nxt;
    logic [31:0] dat_r,       dat_nxt;

    // ==========================================================
    // bus decode
    logic        access;
    logic        wr;
    logic        rd;
    logic [9:0]  idx;
    logic        lane0;
    logic [7:0]  wbyte;

    always_comb begin
        access = wb_cyc_i && wb_stb_i && !ack_r;
        lane0  = wb_sel_i[0];
        wr     = access && wb_we_i && lane0;
        rd     = access && !wb_we_i;
        idx    = wb_adr_i[11:2];
        wbyte  = wb_dat_i[7:0];
    end

    // ==========================================================
    // prescaler and pin clocking
    logic [3:0] taps;
    logic       pin1_pulse;
    logic       pin0_pulse;
    logic       halted;

    assign halted = pre_rst_r;

    shared_prescaler u_prescaler (
        .clk_i             (clk_i),
        .rst_i             (rst_i),
        .prescaler_reset_i (pre_rst_r),
        .taps_o            (taps)
    );

    pin_edge_sync u_pin1 (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .pin_i          (ext_count_pin1_i),
        .clock_select_i (ctrl_b_r[2:0]),
        .pulse_o        (pin1_pulse)
    );

    pin_edge_sync u_pin0 (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .pin_i          (ext_count_pin0_i),
        .clock_select_i (t0_sel_r),
        .pulse_o        (pin0_pulse)
    );

    // each timer picks its own source from the common taps
    always_comb begin
        timer1_tick_o = pick_tick(ctrl_b_r[2:0], taps, pin1_pulse, halted);
        timer0_tick_o = pick_tick(t0_sel_r, taps, pin0_pulse, halted);
    end

    // ==========================================================
    // capture event
    logic cap_src;
    logic cap_edge;
    logic cap_as_top;

    always_comb begin
        cap_as_top = cap_is_top(ctrl_a_r[3:0]);
        cap_src    = ctrl_b_r[BIT_CAP_SRC] ? comparator_i : capture_pin_i;
        cap_prev_nxt = cap_src;
        if (ctrl_b_r[BIT_CAP_EDGE])
            cap_edge = cap_src && !cap_prev_r;
        else
            cap_edge = !cap_src && cap_prev_r;
        // pin is disconnected while the capture register defines top
        cap_edge = cap_edge && !cap_as_top;
    end

    // ==========================================================
    // flag events
    logic [7:0] set_ev;
    logic [7:0] clr_ev;

    always_comb begin
        set_ev = 8'h00;
        set_ev[BIT_CAPTURE] = cap_edge || (cap_as_top && top_i);
        // only true matches reach here, never a forced strobe
        set_ev[BIT_CMP_A] = timer1_tick_o && cmp_a_match_i;
        set_ev[BIT_CMP_B] = timer1_tick_o && cmp_b_match_i;
        set_ev[BIT_OVF]   = overflow_i;
        clr_ev = 8'h00;
        clr_ev[BIT_OVF]     = vector_ack_i[0];
        clr_ev[BIT_CMP_A]   = vector_ack_i[1];
        clr_ev[BIT_CMP_B]   = vector_ack_i[2];
        clr_ev[BIT_CAPTURE] = vector_ack_i[3];
        if (wr && idx == IDX_IRQ_FLAGS)
            clr_ev = clr_ev | (wbyte & IRQ_BITS_MASK);
    end

    // ==========================================================
    // register next state
    always_comb begin
        irq_mask_nxt  = irq_mask_r;
        capture_nxt   = capture_r;
        temp_nxt      = temp_r;
        ctrl_a_nxt    = ctrl_a_r;
        ctrl_b_nxt    = ctrl_b_r;
        t0_sel_nxt    = t0_sel_r;
        sync_hold_nxt = sync_hold_r;
        pre_rst_nxt   = pre_rst_r;
        // set is applied last so it wins over any clear
        flags_nxt = ((flags_r & ~clr_ev) | set_ev) & IRQ_BITS_MASK;
        if (cap_edge)
            capture_nxt = count_value_i;
        // self-clearing unless the hold mode keeps it
        if (!sync_hold_r)
            pre_rst_nxt = 1'b0;
        if (wr) begin
            case (idx)
                IDX_IRQ_MASK: irq_mask_nxt = wbyte & IRQ_BITS_MASK;
                IDX_CAP_HI:   temp_nxt = wbyte;
                IDX_CAP_LO: begin
                    if (!cap_edge)
                        capture_nxt = {temp_r, wbyte};
                end
                IDX_CTRL_A: ctrl_a_nxt = {4'h0, wbyte[3:0]};
                IDX_CTRL_B: ctrl_b_nxt = {wbyte[7:5], 2'b00, wbyte[2:0]};
                IDX_T0_SEL: t0_sel_nxt = wbyte[2:0];
                IDX_PRESCALE: begin
                    sync_hold_nxt = wbyte[BIT_SYNC_HLD];
                    if (wbyte[BIT_PRE_RST])
                        pre_rst_nxt = 1'b1;
                    // leaving hold mode releases every timer at once
                    if (!wbyte[BIT_SYNC_HLD] && !wbyte[BIT_PRE_RST])
                        pre_rst_nxt = 1'b0;
                    else if (wbyte[BIT_SYNC_HLD] && sync_hold_r)
                        pre_rst_nxt = wbyte[BIT_PRE_RST] || pre_rst_r;
                end
                default: ;
            endcase
        end
        // low byte read stages the high byte for a coherent pair
        if (rd && idx == IDX_CAP_LO)
            temp_nxt = capture_r[15:8];
    end

    // ==========================================================
    // bus answer, one wait state for every access
    always_comb begin
        ack_nxt = access;
        dat_nxt = 32'h0000_0000;
        if (rd) begin
            case (idx)
                IDX_IRQ_MASK:  dat_nxt[7:0] = irq_mask_r & IRQ_BITS_MASK;
                IDX_IRQ_FLAGS: dat_nxt[7:0] = flags_r & IRQ_BITS_MASK;
                IDX_CAP_LO:    dat_nxt[7:0] = capture_r[7:0];
                IDX_CAP_HI:    dat_nxt[7:0] = temp_r;
                IDX_CTRL_A:    dat_nxt[7:0] = ctrl_a_r;
                IDX_CTRL_B:    dat_nxt[7:0] = ctrl_b_r;
                IDX_T0_SEL:    dat_nxt[7:0] = {5'h00, t0_sel_r};
                IDX_PRESCALE:  dat_nxt[7:0] = {sync_hold_r, 6'h00, pre_rst_r};
                default:       dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // registers
    // one block per register keeps each reset value beside its flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_r <= IRQ_MASK_RST;
        end else begin
            irq_mask_r <= irq_mask_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_r <= FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_r <= 16'h0000;
        end else begin
            capture_r <= capture_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            temp_r <= 8'h00;
        end else begin
            temp_r <= temp_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_a_r <= CTRL_RST;
        end else begin
            ctrl_a_r <= ctrl_a_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_b_r <= CTRL_RST;
        end else begin
            ctrl_b_r <= ctrl_b_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t0_sel_r <= CS_STOP;
        end else begin
            t0_sel_r <= t0_sel_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_rst_r <= 1'b0;
        end else begin
            pre_rst_r <= pre_rst_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_hold_r <= 1'b0;
        end else begin
            sync_hold_r <= sync_hold_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_prev_r <= 1'b0;
        end else begin
            cap_prev_r <= cap_prev_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else begin
            dat_r <= dat_nxt;
        end
    end

    // ==========================================================
    // outputs
    always_comb begin
        wb_ack_o = ack_r;
        wb_dat_o = dat_r;
        timer1_clock_select_o = ctrl_b_r[2:0];
        timer0_clock_select_o = t0_sel_r;
        waveform_mode_o = ctrl_a_r[3:0];
        capture_value_o = capture_r;
        irq_req_o[0] = global_irq_enable_i && irq_mask_r[BIT_OVF]
                       && flags_r[BIT_OVF];
        irq_req_o[1] = global_irq_enable_i && irq_mask_r[BIT_CMP_A]
                       && flags_r[BIT_CMP_A];
        irq_req_o[2] = global_irq_enable_i && irq_mask_r[BIT_CMP_B]
                       && flags_r[BIT_CMP_B];
        irq_req_o[3] = global_irq_enable_i && irq_mask_r[BIT_CAPTURE]
                       && flags_r[BIT_CAPTURE];
    end
endmodule

// ==== timer_chk_sva.sv ====
`timescale 1ns/1ps
module timer_chk
    import timer_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        ext_count_pin1_i,
    input wire logic        overflow_i,
    input wire logic        global_irq_enable_i,
    input wire logic [3:0]  vector_ack_i,
    input wire logic        timer1_tick_o,
    input wire logic        timer0_tick_o,
    input wire logic [2:0]  timer1_clock_select_o,
    input wire logic [2:0]  timer0_clock_select_o,
    input wire logic [3:0]  irq_req_o
);
    import timer_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // bus
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits set");
    // ==========================================================
    // interrupts and ticks
    irq_gate_a: assert property (|irq_req_o |-> global_irq_enable_i)
        else $error("request without global enable");
    vec_clear_a: assert property (vector_ack_i[0] && !overflow_i |=> !irq_req_o[0])
        else $error("vector did not clear overflow");
    t1_stop_a: assert property (timer1_clock_select_o == CS_STOP |-> !timer1_tick_o)
        else $error("timer1 ticks while stopped");
    t0_stop_a: assert property (timer0_clock_select_o == CS_STOP |-> !timer0_tick_o)
        else $error("timer0 ticks while stopped");
    // a slower tap cannot fire twice inside eight cycles
    div8_gap_a: assert property (timer1_clock_select_o == CS_DIV8 && timer1_tick_o
        |=> (!timer1_tick_o || timer1_clock_select_o != CS_DIV8) [*7])
        else $error("divide by 8 tap too fast");
    ext_lat_a: assert property (timer1_clock_select_o == CS_EXT_RISE &&
        $rose(ext_count_pin1_i) |-> ##[1:3] timer1_tick_o)
        else $error("pin edge not counted in time");
    cover property (wb_ack_o && wb_cyc_i);
    cover property (|irq_req_o);
    cover property (timer1_tick_o && timer1_clock_select_o == CS_EXT_RISE);
endmodule

bind timer_capture_irq timer_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_count_pin1_i(ext_count_pin1_i), .overflow_i(overflow_i),
    .global_irq_enable_i(global_irq_enable_i), .vector_ack_i(vector_ack_i),
    .timer1_tick_o(timer1_tick_o), .timer0_tick_o(timer0_tick_o),
    .timer1_clock_select_o(timer1_clock_select_o),
    .timer0_clock_select_o(timer0_clock_select_o), .irq_req_o(irq_req_o));

// ==== timer_pkg.sv ====
package timer_pkg;
    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_IRQ_MASK  = 10'h06F;
    localparam logic [9:0] IDX_IRQ_FLAGS = 10'h036;
    localparam logic [9:0] IDX_CAP_LO    = 10'h086;
    localparam logic [9:0] IDX_CAP_HI    = 10'h087;
    localparam logic [9:0] IDX_CTRL_A    = 10'h080;
    localparam logic [9:0] IDX_CTRL_B    = 10'h081;
    localparam logic [9:0] IDX_T0_SEL    = 10'h045;
    localparam logic [9:0] IDX_PRESCALE  = 10'h043;
    // ==========================================================
    // field positions
    localparam int BIT_OVF      = 0;
    localparam int BIT_CMP_A    = 1;
    localparam int BIT_CMP_B    = 2;
    localparam int BIT_CAPTURE  = 5;
    localparam logic [7:0] IRQ_BITS_MASK = 8'h27;
    localparam int BIT_CAP_EDGE = 6;
    localparam int BIT_CAP_SRC  = 5;
    localparam int BIT_PRE_RST  = 0;
    localparam int BIT_SYNC_HLD = 7;
    // ==========================================================
    // reset values
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST    = 8'h00;
    localparam logic [7:0] CTRL_RST     = 8'h00;
    // ==========================================================
    // clock select codes and prescaler taps
    localparam logic [2:0] CS_STOP    = 3'h0;
    localparam logic [2:0] CS_DIRECT  = 3'h1;
    localparam logic [2:0] CS_DIV8    = 3'h2;
    localparam logic [2:0] CS_DIV64   = 3'h3;
    localparam logic [2:0] CS_DIV256  = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam int PRESCALE_BITS = 10;
    // waveform modes with the capture register as top
    localparam logic [3:0] WM_PFC_CAP  = 4'h8;
    localparam logic [3:0] WM_PC_CAP   = 4'hA;
    localparam logic [3:0] WM_CTC_CAP  = 4'hC;
    localparam logic [3:0] WM_FAST_CAP = 4'hE;

    function automatic logic pick_tick(input logic [2:0] cs,
                                       input logic [3:0] taps,
                                       input logic       pin_pulse,
                                       input logic       halted);
        logic t;
        t = 1'b0;
        case (cs)
            CS_DIRECT:   t = !halted;
            CS_DIV8:     t = taps[0];
            CS_DIV64:    t = taps[1];
            CS_DIV256:   t = taps[2];
            CS_DIV1024:  t = taps[3];
            CS_EXT_FALL: t = pin_pulse;
            CS_EXT_RISE: t = pin_pulse;
            default:     t = 1'b0;
        endcase
        return t;
    endfunction

    function automatic logic cap_is_top(input logic [3:0] wm);
        return (wm == WM_PFC_CAP) || (wm == WM_PC_CAP) ||
               (wm == WM_CTC_CAP) || (wm == WM_FAST_CAP);
    endfunction
endpackage

// ==== wb_cpu.sv ====
`timescale 1ns/1ps
module wb_cpu (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [11:0]      adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o
);
    initial begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end
    // ==========================================================
    // one classic cycle; the leading edge wait keeps one idle cycle between
    task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= {idx, 2'b00};
        sel_o <= 4'hF;
        dat_o <= {24'h000000, d};
        do begin
            @(posedge clk_i);
        end while (ack_i !== 1'b1);
        q = dat_i[7:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
    endtask
endmodule
